// *** design/uifc_pkg.sv ***
// Constants for the UART interrupt and queue control block
package uifc_pkg;
   // Register addresses on the A2-A0 bus
   localparam logic [2:0] ADDR_RXHOLD = 3'h0;
   localparam logic [2:0] ADDR_MASK = 3'h1;
   localparam logic [2:0] ADDR_STATUS = 3'h2;
   localparam logic [2:0] ADDR_QCTRL = 3'h2;
   localparam logic [2:0] ADDR_LINE = 3'h5;
   localparam logic [2:0] ADDR_MODEM = 3'h6;
   // Interrupt source codes, status bits 5:0
   localparam logic [5:0] ID_LINE = 6'h06;
   localparam logic [5:0] ID_TOUT = 6'h0c;
   localparam logic [5:0] ID_RECEIVE_READY_SOURCE = 6'h04;
   localparam logic [5:0] ID_TRANSMIT_READY_SOURCE = 6'h02;
   localparam logic [5:0] ID_MODEM = 6'h00;
   localparam logic [5:0] ID_XOFF = 6'h10;
   localparam logic [5:0] ID_FLOW = 6'h20;
   localparam logic [5:0] ID_NONE = 6'h01;
   // Interrupt mask bit positions
   localparam int MB_RX = 0;
   localparam int MB_TX = 1;
   localparam int MB_LINE = 2;
   localparam int MB_MODEM = 3;
   localparam int MB_SLEEP = 4;
   localparam int MB_XOFF = 5;
   localparam int MB_RTS = 6;
   localparam int MB_CTS = 7;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] MASK_ENH = 8'hf0;
   // Queue control bit positions
   localparam int QC_EN = 0;
   localparam int QC_RXRST = 1;
   // Receive time-out span
   localparam int TOUT_CHARS = 4;
   localparam int TOUT_EXTRA_BITS = 12;
   localparam int TMR_W = 8;
endpackage : uifc_pkg

// *** design/uifc_core.sv ***
// UART channel interrupt enable, status and queue control logic
// What this block does
// - FIFO receive interrupt follows trigger level
// - Data-ready sets on push, clears when empty
// - Cleared basic enables give polled mode with enhanced bit off
// - Line status bits assembled as documented
// - Non-FIFO receive interrupt while holding data
// - Transmit ready; enabling while empty raises it
// - Line errors raise line status interrupt
// - Modem deltas raise modem interrupt
// - Upper enables writable only with enhanced bit
// - Auto RTS/CTS rising edges raise interrupt
// - Time-out after four chars plus twelve bits
// - Transmit ready on FIFO empty or below trigger, on transmitter empty only with RS485
// - Xoff or special match raises interrupt
// - Line and modem status reads clear theirs
// - Time-out clears on receive holding read
// - Status read or transmit write clears TX
// - Xoff and special clearing conditions
// - Priority encoding of status bits 5:0
// - Status read reports only highest source
// - Status bits 5:4 need enhanced bit
// - Status bits 7:6 show FIFO enable
// - Queue control bits need enable bit
// - Receive FIFO reset pulses and self-clears
`timescale 1ns/10ps
module uifc_core #(
   parameter int CHAR_BITS = 10,
   parameter int LVL_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic enh_en_i,
   input wire logic auto_rts_i,
   input wire logic auto_cts_i,
   input wire logic rs485_i,
   input wire logic rx_push_i,
   input wire logic [LVL_W-1:0] rx_level_i,
   input wire logic [LVL_W-1:0] rx_trig_i,
   input wire logic overrun_i,
   input wire logic [2:0] head_err_i,
   input wire logic fifo_err_i,
   input wire logic thr_empty_i,
   input wire logic tx_below_trig_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_all_empty_i,
   input wire logic [3:0] modem_delta_i,
   input wire logic [7:0] modem_status_i,
   input wire logic xoff_match_i,
   input wire logic xon_match_i,
   input wire logic special_match_i,
   input wire logic bit_tick_i,
   input wire logic rts_n_i,
   input wire logic cts_n_i,
   output logic irq_o,
   output logic fifo_en_o,
   output logic rx_fifo_reset_o,
   output logic [7:0] mask_o
);

   localparam int TOUT_LIMIT = uifc_pkg::TOUT_CHARS * CHAR_BITS + uifc_pkg::TOUT_EXTRA_BITS;

   if (CHAR_BITS < 5 || CHAR_BITS > 16) begin : g_chk_char
      $error("CHAR_BITS out of range");
   end
   if (LVL_W < 1 || LVL_W > 16) begin : g_chk_lvl
      $error("LVL_W out of range");
   end
   if (TOUT_LIMIT >= (1 << uifc_pkg::TMR_W)) begin : g_chk_tout
      $error("time-out span exceeds timer width");
   end

   // Priority encoder of pending sources
   function automatic logic [5:0] enc_id(input logic [6:0] p);
      logic [5:0] r;
      r = uifc_pkg::ID_NONE;
      if (p[0]) begin
         r = uifc_pkg::ID_LINE;
      end else if (p[1]) begin
         r = uifc_pkg::ID_TOUT;
      end else if (p[2]) begin
         r = uifc_pkg::ID_RECEIVE_READY_SOURCE;
      end else if (p[3]) begin
         r = uifc_pkg::ID_TRANSMIT_READY_SOURCE;
      end else if (p[4]) begin
         r = uifc_pkg::ID_MODEM;
      end else if (p[5]) begin
         r = uifc_pkg::ID_XOFF;
      end else if (p[6]) begin
         r = uifc_pkg::ID_FLOW;
      end
      return r;
   endfunction : enc_id

   function automatic logic rise(input logic now, input logic prev);
      return now & ~prev;
   endfunction : rise

   localparam int TMR_W_L = uifc_pkg::TMR_W;

   logic [7:0] mask_q;
   logic [7:0] rdata_q;
   logic [TMR_W_L-1:0] tmr_q;
   logic fifo_en_q, rxrst_q, dr_q, line_q, tout_q, transmit_ready_source_q, modem_q, xoff_q, spec_q, flow_q, irq_q;
   logic ovr_p_q, thr_p_q, below_p_q, fempty_p_q, all_p_q, rts_p_q;
   logic cts_s1_q, cts_s2_q, cts_s3_q, cts_q;

   // Bus decode
   logic rd_rhr, rd_isr, rd_lsr, rd_msr, wr_mask, wr_qc, wr_thr;
   assign rd_rhr = rd_i && addr_i == uifc_pkg::ADDR_RXHOLD;
   assign rd_isr = rd_i && addr_i == uifc_pkg::ADDR_STATUS;
   assign rd_lsr = rd_i && addr_i == uifc_pkg::ADDR_LINE;
   assign rd_msr = rd_i && addr_i == uifc_pkg::ADDR_MODEM;
   assign wr_mask = wr_i && addr_i == uifc_pkg::ADDR_MASK;
   assign wr_qc = wr_i && addr_i == uifc_pkg::ADDR_QCTRL;
   assign wr_thr = wr_i && addr_i == uifc_pkg::ADDR_RXHOLD;

   // Source conditions
   logic rx_has;
   logic rx_trig;
   logic receive_ready_source_src;
   logic tx_empty_now;
   logic tx_evt;
   logic tx_en_evt;
   logic line_evt;
   logic cts_stable;
   logic [6:0] pend;
   logic [5:0] id;

   assign rx_has = rx_level_i != '0;
   assign rx_trig = rx_level_i >= rx_trig_i;
   assign receive_ready_source_src = fifo_en_q ? rx_trig : rx_has;
   assign tx_empty_now = fifo_en_q ? (tx_below_trig_i | tx_fifo_empty_i) : thr_empty_i;
   assign tx_evt = fifo_en_q ?
      (rise(tx_below_trig_i, below_p_q) | rise(tx_fifo_empty_i, fempty_p_q) |
       (rs485_i & rise(tx_all_empty_i, all_p_q))) :
      rise(thr_empty_i, thr_p_q);
   assign tx_en_evt = wr_mask & wdata_i[uifc_pkg::MB_TX] & ~mask_q[uifc_pkg::MB_TX] & tx_empty_now;
   assign line_evt = (rx_push_i & (|head_err_i)) | rise(overrun_i, ovr_p_q);

   // Pending, gated by enables; all clear gives polled mode
   assign pend[0] = line_q & mask_q[uifc_pkg::MB_LINE];
   assign pend[1] = tout_q & mask_q[uifc_pkg::MB_RX];
   assign pend[2] = receive_ready_source_src & mask_q[uifc_pkg::MB_RX];
   assign pend[3] = transmit_ready_source_q & mask_q[uifc_pkg::MB_TX];
   assign pend[4] = modem_q & mask_q[uifc_pkg::MB_MODEM];
   assign pend[5] = (xoff_q | spec_q) & mask_q[uifc_pkg::MB_XOFF] & enh_en_i;
   assign pend[6] = flow_q & enh_en_i;
   assign id = enc_id(pend);

   // Interrupt mask register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mask_q <= uifc_pkg::MASK_RESET;
      end else if (wr_mask) begin
         if (enh_en_i) begin
            mask_q <= wdata_i;
         end else begin
            mask_q <= (mask_q & uifc_pkg::MASK_ENH) | (wdata_i & ~uifc_pkg::MASK_ENH);
         end
      end
   end

   // Queue control: enable and receive reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fifo_en_q <= 1'b0;
         rxrst_q <= 1'b0;
      end else begin
         rxrst_q <= 1'b0;
         if (wr_qc) begin
            fifo_en_q <= wdata_i[uifc_pkg::QC_EN];
            rxrst_q <= wdata_i[uifc_pkg::QC_EN] & wdata_i[uifc_pkg::QC_RXRST];
         end
      end
   end

   // Receive data ready flag
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dr_q <= 1'b0;
      end else if (rx_push_i) begin
         dr_q <= 1'b1;
      end else if (!rx_has || rxrst_q) begin
         dr_q <= 1'b0;
      end
   end

   // Line status interrupt
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_q <= 1'b0;
      end else if (line_evt) begin
         line_q <= 1'b1;
      end else if (rd_lsr) begin
         line_q <= 1'b0;
      end
   end

   // Receive time-out timer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tmr_q <= '0;
      end else if (rx_push_i || rd_rhr || !rx_has || rxrst_q) begin
         tmr_q <= '0;
      end else if (bit_tick_i && tmr_q < TMR_W_L'(TOUT_LIMIT)) begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tout_q <= 1'b0;
      end else if (fifo_en_q && rx_has && bit_tick_i && tmr_q == TMR_W_L'(TOUT_LIMIT - 1)) begin
         tout_q <= 1'b1;
      end else if (rd_rhr || !rx_has) begin
         tout_q <= 1'b0;
      end
   end

   // Transmit ready interrupt
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         transmit_ready_source_q <= 1'b0;
      end else if ((tx_evt & mask_q[uifc_pkg::MB_TX]) | tx_en_evt) begin
         transmit_ready_source_q <= 1'b1;
      end else if (wr_thr || (rd_isr && id == uifc_pkg::ID_TRANSMIT_READY_SOURCE)) begin
         transmit_ready_source_q <= 1'b0;
      end
   end

   // Modem status interrupt
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         modem_q <= 1'b0;
      end else if (|modem_delta_i) begin
         modem_q <= 1'b1;
      end else if (rd_msr) begin
         modem_q <= 1'b0;
      end
   end

   // Xoff and special character interrupts
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         xoff_q <= 1'b0;
      end else if (xoff_match_i) begin
         xoff_q <= 1'b1;
      end else if (xon_match_i || (rd_isr && id == uifc_pkg::ID_XOFF)) begin
         xoff_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         spec_q <= 1'b0;
      end else if (special_match_i) begin
         spec_q <= 1'b1;
      end else if (rx_push_i || (rd_isr && id == uifc_pkg::ID_XOFF)) begin
         spec_q <= 1'b0;
      end
   end

   // CTS pin synchroniser and stable level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cts_s1_q <= 1'b1;
         cts_s2_q <= 1'b1;
         cts_s3_q <= 1'b1;
      end else begin
         cts_s1_q <= cts_n_i;
         cts_s2_q <= cts_s1_q;
         cts_s3_q <= cts_s2_q;
      end
   end

   assign cts_stable = (cts_s2_q == cts_s3_q) ? cts_s3_q : cts_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cts_q <= 1'b1;
      end else begin
         cts_q <= cts_stable;
      end
   end

   // Flow control change interrupt
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flow_q <= 1'b0;
      end else if ((auto_rts_i & mask_q[uifc_pkg::MB_RTS] & rise(rts_n_i, rts_p_q)) |
                   (auto_cts_i & mask_q[uifc_pkg::MB_CTS] & rise(cts_stable, cts_q))) begin
         flow_q <= 1'b1;
      end else if (rd_msr) begin
         flow_q <= 1'b0;
      end
   end

   // Previous values for edge detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ovr_p_q <= 1'b0;
         thr_p_q <= 1'b1;
         below_p_q <= 1'b1;
         fempty_p_q <= 1'b1;
         all_p_q <= 1'b1;
         rts_p_q <= 1'b1;
      end else begin
         ovr_p_q <= overrun_i;
         thr_p_q <= thr_empty_i;
         below_p_q <= tx_below_trig_i;
         fempty_p_q <= tx_fifo_empty_i;
         all_p_q <= tx_all_empty_i;
         rts_p_q <= rts_n_i;
      end
   end

   // Registered read data
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else if (rd_i) begin
         case (addr_i)
            uifc_pkg::ADDR_MASK: rdata_q <= mask_q;
            uifc_pkg::ADDR_STATUS: rdata_q <= {{2{fifo_en_q}}, id};
            uifc_pkg::ADDR_LINE: rdata_q <= {fifo_err_i, tx_all_empty_i, thr_empty_i,
                                             head_err_i, overrun_i, dr_q};
            uifc_pkg::ADDR_MODEM: rdata_q <= modem_status_i;
            default: rdata_q <= '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |pend;
      end
   end

   assign rdata_o = rdata_q;
   assign irq_o = irq_q;
   assign fifo_en_o = fifo_en_q;
   assign rx_fifo_reset_o = rxrst_q;
   assign mask_o = mask_q;

   a_rx_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
      fifo_en_q && mask_q[0] && rx_trig && !pend[0] && !pend[1] |-> id == uifc_pkg::ID_RECEIVE_READY_SOURCE)
      else $error("receive trigger not reported");

   a_dr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      !rx_has && !rx_push_i |=> !dr_q)
      else $error("data ready stuck with empty fifo");

   a_line_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_lsr |=> rdata_o[5] == $past(thr_empty_i) && rdata_o[0] == $past(dr_q))
      else $error("line status bits wrong");

   a_tx_enable: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mask && wdata_i[1] && !mask_q[1] && !fifo_en_q && thr_empty_i |=> transmit_ready_source_q)
      else $error("transmit ready not raised on enable");

   a_modem_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_msr && modem_delta_i == 4'h0 |=> !modem_q)
      else $error("modem interrupt not cleared");

   a_status_fifo: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_isr |=> rdata_o[7:6] == {2{$past(fifo_en_q)}})
      else $error("fifo enable bits wrong");

   a_irq_none: assert property (@(posedge clk_i) disable iff (rst_i)
      id == uifc_pkg::ID_NONE |=> !irq_o)
      else $error("interrupt active with none pending");

   a_rxrst_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_fifo_reset_o && !wr_qc |=> !rx_fifo_reset_o)
      else $error("receive reset did not self clear");

   a_enh_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mask && !enh_en_i |=> mask_q[7:4] == $past(mask_q[7:4]))
      else $error("upper enables written without enhanced bit");

   a_tout_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_rhr && !bit_tick_i |=> !tout_q)
      else $error("time-out not cleared by read");

endmodule : uifc_core

// *** tb/uifc_host.sv ***
// Host processor model issuing register reads and writes
`timescale 1ns/10ps
module uifc_host (
   input wire logic clk_i,
   output logic [2:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   initial begin
      addr_o = 3'h7;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'h00;
   end

   // One write cycle, released after the taking edge
   task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : write_reg

   // One read cycle, data taken in the following cycle
   task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(negedge clk_i);
      d = rdata_i;
      @(posedge clk_i);
   endtask : read_reg
endmodule : uifc_host

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt and queue control block
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] addr;
   logic rd, wr, irq, fen, frst;
   logic [7:0] wdata, rdata, mask, lvl, trig, mstat;
   logic enh, a_rts, a_cts, rs485, push, ovr, ferr, thre, txbt, txfe, txae, xoff, xon, spc, tick;
   logic rts_n, cts_n;
   logic [2:0] herr;
   logic [3:0] mdelta;
   logic [7:0] d;
   int num_errors = 0;
   int n_compared = 0;

   always #20 clk_i = ~clk_i;

   uifc_host host (.clk_i(clk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .rdata_i(rdata));

   uifc_core #(.CHAR_BITS(5), .LVL_W(8)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
      .rdata_o(rdata), .enh_en_i(enh), .auto_rts_i(a_rts), .auto_cts_i(a_cts), .rs485_i(rs485),
      .rx_push_i(push), .rx_level_i(lvl), .rx_trig_i(trig), .overrun_i(ovr), .head_err_i(herr),
      .fifo_err_i(ferr), .thr_empty_i(thre), .tx_below_trig_i(txbt), .tx_fifo_empty_i(txfe),
      .tx_all_empty_i(txae), .modem_delta_i(mdelta), .modem_status_i(mstat), .xoff_match_i(xoff),
      .xon_match_i(xon), .special_match_i(spc), .bit_tick_i(tick), .rts_n_i(rts_n), .cts_n_i(cts_n),
      .irq_o(irq), .fifo_en_o(fen), .rx_fifo_reset_o(frst), .mask_o(mask));

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      host.read_reg(a, v);
      check(what, exp, v);
   endtask : rdc

   task automatic wait_irq(input logic v);
      for (int i = 0; i < 12; i++) begin
         @(negedge clk_i);
         if (irq === v) begin
            @(posedge clk_i);
            return;
         end
      end
      check("irq wait", {7'h00, v}, {7'h00, irq});
      stop_test();
   endtask : wait_irq

   task automatic do_reset;
      rst_i <= 1'b1;
      {enh, a_rts, a_cts, rs485, push, ovr, ferr, thre, txbt, txfe, txae, xoff, xon, spc, tick} <= 15'h0000;
      {rts_n, cts_n, herr, mdelta} <= 9'h180;
      lvl <= 8'h00;
      trig <= 8'h01;
      mstat <= 8'h5a;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset

   task automatic tick_n(input int n);
      repeat (n) begin
         tick <= 1'b1;
         @(posedge clk_i);
         tick <= 1'b0;
         @(posedge clk_i);
      end
   endtask : tick_n

   task automatic t_mask;
      do_reset();
      check("mask reset", 8'h00, mask);
      check("irq reset", 8'h00, {7'h00, irq});
      rdc(uifc_pkg::ADDR_STATUS, 8'h01, "status reset");
      host.write_reg(uifc_pkg::ADDR_MASK, 8'hf0);
      rdc(uifc_pkg::ADDR_MASK, 8'h00, "mask locked");
      rdc(3'h7, 8'h00, "unmapped read");
      {thre, txae, ferr, ovr} <= 4'hf;
      rdc(uifc_pkg::ADDR_LINE, 8'he2, "line status");
   endtask : t_mask

   task automatic t_queue;
      do_reset();
      host.write_reg(uifc_pkg::ADDR_QCTRL, 8'h03);
      @(negedge clk_i);
      check("fifo enable", 8'h01, {7'h00, fen});
      check("rx reset pulse", 8'h01, {7'h00, frst});
      @(negedge clk_i);
      check("rx reset end", 8'h00, {7'h00, frst});
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status fifo on");
      host.write_reg(uifc_pkg::ADDR_QCTRL, 8'h02);
      @(negedge clk_i);
      check("rx reset ignored", 8'h00, {7'h00, frst});
      check("fifo disable", 8'h00, {7'h00, fen});
      rdc(uifc_pkg::ADDR_STATUS, 8'h01, "status fifo off");
   endtask : t_queue

   task automatic t_rx;
      do_reset();
      host.write_reg(uifc_pkg::ADDR_QCTRL, 8'h01);
      trig <= 8'h04;
      lvl <= 8'h04;
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status polled");
      check("irq polled", 8'h00, {7'h00, irq});
      host.write_reg(uifc_pkg::ADDR_MASK, 8'h05);
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'hc4, "status rx");
      herr <= 3'h1;
      push <= 1'b1;
      @(posedge clk_i);
      push <= 1'b0;
      rdc(uifc_pkg::ADDR_STATUS, 8'hc6, "status line");
      rdc(uifc_pkg::ADDR_LINE, 8'h05, "line with error");
      rdc(uifc_pkg::ADDR_STATUS, 8'hc4, "status queued rx");
      lvl <= 8'h00;
      herr <= 3'h0;
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status below trig");
      rdc(uifc_pkg::ADDR_LINE, 8'h00, "line empty");
   endtask : t_rx

   task automatic t_timeout;
      do_reset();
      host.write_reg(uifc_pkg::ADDR_QCTRL, 8'h01);
      host.write_reg(uifc_pkg::ADDR_MASK, 8'h01);
      trig <= 8'h04;
      lvl <= 8'h01;
      push <= 1'b1;
      @(posedge clk_i);
      push <= 1'b0;
      tick_n(31);
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status before timeout");
      tick_n(1);
      rdc(uifc_pkg::ADDR_STATUS, 8'hcc, "status timeout");
      host.read_reg(uifc_pkg::ADDR_RXHOLD, d);
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status after hold read");
   endtask : t_timeout

   task automatic t_tx;
      do_reset();
      thre <= 1'b1;
      host.write_reg(uifc_pkg::ADDR_MASK, 8'h02);
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'h02, "status tx");
      wait_irq(1'b0);
      thre <= 1'b0;
      @(posedge clk_i);
      thre <= 1'b1;
      wait_irq(1'b1);
      host.write_reg(uifc_pkg::ADDR_RXHOLD, 8'h55);
      wait_irq(1'b0);
      host.write_reg(uifc_pkg::ADDR_QCTRL, 8'h01);
      txfe <= 1'b1;
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'hc2, "status tx fifo");
   endtask : t_tx

   task automatic t_events;
      do_reset();
      enh <= 1'b1;
      a_cts <= 1'b1;
      cts_n <= 1'b0;
      host.write_reg(uifc_pkg::ADDR_MASK, 8'ha8);
      rdc(uifc_pkg::ADDR_MASK, 8'ha8, "mask enhanced");
      mdelta <= 4'h2;
      wait_irq(1'b1);
      mdelta <= 4'h0;
      rdc(uifc_pkg::ADDR_STATUS, 8'h00, "status modem");
      rdc(uifc_pkg::ADDR_MODEM, 8'h5a, "modem read");
      rdc(uifc_pkg::ADDR_STATUS, 8'h01, "status modem cleared");
      xoff <= 1'b1;
      @(posedge clk_i);
      xoff <= 1'b0;
      rdc(uifc_pkg::ADDR_STATUS, 8'h10, "status xoff");
      rdc(uifc_pkg::ADDR_STATUS, 8'h01, "status xoff cleared");
      cts_n <= 1'b1;
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'h20, "status flow");
      host.read_reg(uifc_pkg::ADDR_MODEM, d);
      wait_irq(1'b0);
   endtask : t_events

   task automatic t_nofifo;
      do_reset();
      trig <= 8'h04;
      host.write_reg(uifc_pkg::ADDR_MASK, 8'h05);
      rdc(uifc_pkg::ADDR_STATUS, 8'h01, "status no data");
      lvl <= 8'h01;
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'h04, "status rx no fifo");
      ovr <= 1'b1;
      rdc(uifc_pkg::ADDR_STATUS, 8'h06, "status overrun");
      rdc(uifc_pkg::ADDR_LINE, 8'h02, "line overrun");
      rdc(uifc_pkg::ADDR_STATUS, 8'h04, "status line cleared");
      lvl <= 8'h00;
      wait_irq(1'b0);
   endtask : t_nofifo

   task automatic t_flow;
      do_reset();
      enh <= 1'b1;
      a_rts <= 1'b1;
      rs485 <= 1'b1;
      host.write_reg(uifc_pkg::ADDR_QCTRL, 8'h01);
      host.write_reg(uifc_pkg::ADDR_MASK, 8'h62);
      txae <= 1'b1;
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'hc2, "status rs485 empty");
      wait_irq(1'b0);
      rts_n <= 1'b0;
      @(posedge clk_i);
      rts_n <= 1'b1;
      wait_irq(1'b1);
      rdc(uifc_pkg::ADDR_STATUS, 8'he0, "status rts rise");
      rdc(uifc_pkg::ADDR_MODEM, 8'h5a, "modem read rts");
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status rts cleared");
      xoff <= 1'b1;
      @(posedge clk_i);
      xoff <= 1'b0;
      xon <= 1'b1;
      @(posedge clk_i);
      xon <= 1'b0;
      rdc(uifc_pkg::ADDR_STATUS, 8'hc1, "status after xon");
      spc <= 1'b1;
      @(posedge clk_i);
      spc <= 1'b0;
      wait_irq(1'b1);
      push <= 1'b1;
      @(posedge clk_i);
      push <= 1'b0;
      wait_irq(1'b0);
   endtask : t_flow

   initial begin
      do_reset();
      t_mask();
      t_queue();
      t_rx();
      t_timeout();
      t_tx();
      t_events();
      t_nofifo();
      t_flow();
      stop_test();
   end
endmodule : testbench
